/* File: bench/chs_card_model.sv */
// Card model: config registers, card info and common memory behind strobes
`timescale 1ns/1ps
module chs_card_model
  import chs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [1:0]  mode,
  input  wire logic [9:0]  ext_cycles,
  input  wire logic [10:0] card_addr,
  input  wire logic        low_byte_select_n,
  input  wire logic        high_byte_select_n,
  input  wire logic        attr_select_n,
  input  wire logic        out_strobe_n,
  input  wire logic        wr_strobe_n,
  input  wire logic [15:0] card_data_out,
  input  wire logic        card_data_oe,
  output      logic [15:0] card_data_in,
  output      logic        cycle_hold_n,
  output      logic        pio_extend_n,
  output      logic        burst_accept_n,
  output      logic        read_burst_strobe,
  output      logic        write_protect,
  output      logic        port_word_capable_n,
  output      logic        word_cycle_expect_n,
  output      logic [9:0]  last_len
);
  logic [15:0] cmem [0:1023];
  logic [7:0]  cfg [0:3] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] last = 16'h0000;
  logic [15:0] burst_val = 16'h0000;
  logic [15:0] rd;
  logic [9:0]  cnt = 10'h000;
  logic        bursting = 1'b0;
  logic        lo;
  logic        hi;
  logic        stb;
  logic        ext;
  logic        cfg_hit;
  initial read_burst_strobe = 1'b0;
  initial last_len = 10'h000;
  assign lo = !low_byte_select_n;
  assign hi = !high_byte_select_n;
  assign stb = !out_strobe_n || !wr_strobe_n;
  assign cfg_hit = card_addr[10:3] == 8'h40 && !card_addr[0];
  // ==========================================================
  // Read decode
  always_comb begin
    rd = ~last;
    if (attr_select_n) begin
      if (lo) rd[7:0] = cmem[card_addr[10:1]][7:0];
      if (hi) rd[15:8] = cmem[card_addr[10:1]][15:8];
    end else if (lo && !card_addr[0]) begin
      if (cfg_hit) rd[7:0] = cfg[card_addr[2:1]];
      else if (card_addr[10:9] == 2'b00) rd[7:0] = ~card_addr[8:1];
    end
  end
  // Released bus shows a changing pattern, not the last value
  assign card_data_in = bursting ? burst_val :
                        ((lo || hi) && !out_strobe_n) ? rd : ~last;
  always @(posedge sys_clk) last <= card_data_in;
  // ==========================================================
  // Writes and cycle stretching
  always @(posedge wr_strobe_n) begin
    if (card_data_oe && attr_select_n) begin
      if (lo) cmem[card_addr[10:1]][7:0] = card_data_out[7:0];
      if (hi) cmem[card_addr[10:1]][15:8] = card_data_out[15:8];
    end else if (card_data_oe && lo && cfg_hit)
      cfg[card_addr[2:1]] = card_data_out[7:0];
  end
  always @(posedge sys_clk) begin
    if (stb) cnt <= cnt + 10'd1;
    else if (cnt != 10'd0) begin
      last_len <= cnt;
      cnt <= 10'd0;
    end
  end
  assign ext = stb && cnt < ext_cycles;
  assign cycle_hold_n = !(ext && mode != CHS_MODE_ATA);
  assign pio_extend_n = !(ext && mode == CHS_MODE_ATA);
  assign write_protect = mode != CHS_MODE_MEM;
  assign port_word_capable_n = mode != CHS_MODE_IO;
  assign word_cycle_expect_n = mode != CHS_MODE_ATA;
  // Always ready for a data-out burst while in ATA mode
  assign burst_accept_n = mode != CHS_MODE_ATA;
  task automatic send_burst(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      bursting <= 1'b1;
      burst_val <= 16'h5a00 + 16'(i);
      repeat (2) @(posedge sys_clk);
      read_burst_strobe <= !read_burst_strobe;
      repeat (2) @(posedge sys_clk);
    end
    bursting <= 1'b0;
  endtask
endmodule

/* File: bench/testbench.sv */
// Testbench: host controller against the card model
`timescale 1ns/1ps
module testbench;
  import chs_pkg::*;
  logic        sys_clk;
  logic        arst_n;
  logic        sw_wr;
  logic        sw_rd;
  logic [3:0]  sw_addr;
  logic [15:0] sw_wdata;
  logic [15:0] sw_rdata;
  logic [10:0] card_addr;
  logic        low_byte_select_n;
  logic        high_byte_select_n;
  logic        attr_select_n;
  logic        out_strobe_n;
  logic        wr_strobe_n;
  logic [15:0] card_data_in;
  logic [15:0] card_data_out;
  logic        card_data_oe;
  logic        cycle_hold_n;
  logic        pio_extend_n;
  logic        burst_accept_n;
  logic        read_burst_strobe;
  logic        write_protect;
  logic        port_word_capable_n;
  logic        word_cycle_expect_n;
  logic [1:0]  mode;
  logic [9:0]  ext_cycles;
  logic [9:0]  last_len;
  logic [15:0] rv;
  logic [15:0] st;
  int          fails = 0;
  int          n_checks = 0;
  int          wr_lows = 0;

  chs_host chs_host_inst (.*);
  chs_card_model chs_card_model_inst (.*);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (!wr_strobe_n) wr_lows <= wr_lows + 1;
  // ==========================================================
  // Bus tasks
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic card_op(input logic [1:0] ln, input logic at, input logic w,
                         input logic [10:0] a, input logic [15:0] d);
    sw_write(CHS_REG_ADDR, {5'h00, a});
    sw_write(CHS_REG_WDATA, d);
    sw_write(CHS_REG_CTRL, {11'h000, ln, at, w, 1'b1});
    st = 16'h0001;
    for (int i = 0; i < 200 && st[CHS_ST_BUSY] !== 1'b0; i++)
      sw_read(CHS_REG_STATUS, st);
    check("busy", {15'h0000, st[CHS_ST_BUSY]}, 16'h0000);
    sw_write(CHS_REG_STATUS, 16'h000e);
  endtask
  task automatic rd_card(input logic [1:0] ln, input logic at,
                         input logic [10:0] a, input logic [15:0] exp);
    card_op(ln, at, 1'b0, a, 16'h0000);
    sw_read(CHS_REG_RDATA, rv);
    check("card read", rv, exp);
  endtask
  task automatic refuse(input logic [1:0] ln, input logic at, input logic w,
                        input logic [10:0] a);
    int w0;
    w0 = wr_lows;
    card_op(ln, at, w, a, 16'h00ff);
    check("refused", {15'h0000, st[CHS_ST_REFUSED]}, 16'h0001);
    check("strobe quiet", 16'(wr_lows - w0), 16'h0000);
  endtask
  task automatic set_mode(input logic [1:0] m, input logic b);
    mode <= m;
    sw_write(CHS_REG_MODE, {13'h0000, b, m});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    sw_read(CHS_REG_STATUS, rv);
    check("status", rv & 16'h000f, 16'h0000);
    @(posedge sys_clk);
    #1 check("rdata cleared", sw_rdata, 16'h0000);
    check("standby", {13'h0, low_byte_select_n, high_byte_select_n,
                      card_data_oe}, 16'h0006);
    sw_read(CHS_REG_CFG_BASE, rv);
    check("cfg base", rv, {5'h00, CHS_CFG_BASE_RST});
    sw_read(4'h9, rv);
    check("unmapped", rv, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_common;
    card_op(CHS_LANE_WORD, 1'b0, 1'b1, 11'h010, 16'h1234);
    check("word write", chs_card_model_inst.cmem[8], 16'h1234);
    card_op(CHS_LANE_LOW, 1'b0, 1'b1, 11'h010, 16'h55ab);
    card_op(CHS_LANE_HIGH, 1'b0, 1'b1, 11'h011, 16'hcd66);
    check("lane write", chs_card_model_inst.cmem[8], 16'hcdab);
    rd_card(CHS_LANE_WORD, 1'b0, 11'h010, 16'hcdab);
    rd_card(CHS_LANE_LOW, 1'b0, 11'h010, 16'h00ab);
    rd_card(CHS_LANE_HIGH, 1'b0, 11'h011, 16'hcd00);
    refuse(CHS_LANE_WORD, 1'b0, 1'b1, 11'h011);
    $display("test common done");
  endtask
  task automatic t_attr;
    for (int i = 0; i < 4; i++) begin
      card_op(CHS_LANE_LOW, 1'b1, 1'b1, 11'h200 + 11'(2 * i), 16'h0030 + 16'(i));
      check("cfg reg", {8'h00, chs_card_model_inst.cfg[i]},
            16'h0030 + 16'(i));
      rd_card(CHS_LANE_LOW, 1'b1, 11'h200 + 11'(2 * i), 16'h0030 + 16'(i));
    end
    rd_card(CHS_LANE_LOW, 1'b1, 11'h004, 16'h00fd);
    refuse(CHS_LANE_LOW, 1'b1, 1'b1, 11'h004);
    refuse(CHS_LANE_LOW, 1'b1, 1'b1, 11'h300);
    refuse(CHS_LANE_LOW, 1'b1, 1'b0, 11'h201);
    refuse(CHS_LANE_HIGH, 1'b1, 1'b0, 11'h200);
    $display("test attribute done");
  endtask
  task automatic t_extend;
    set_mode(CHS_MODE_IO, 1'b0);
    rd_card(CHS_LANE_WORD, 1'b0, 11'h010, 16'hcdab);
    check("plain len", {6'h00, last_len}, {7'h00, CHS_STROBE_CYC});
    ext_cycles <= 10'd7;
    rd_card(CHS_LANE_WORD, 1'b0, 11'h010, 16'hcdab);
    check("hold len", 16'(last_len > 10'd7 && last_len < 10'd13), 16'h1);
    refuse(CHS_LANE_WORD, 1'b0, 1'b1, 11'h010);
    card_op(CHS_LANE_LOW, 1'b1, 1'b1, 11'h202, 16'h00a7);
    check("io cfg write", {8'h00, chs_card_model_inst.cfg[1]}, 16'h00a7);
    set_mode(CHS_MODE_ATA, 1'b0);
    rd_card(CHS_LANE_WORD, 1'b0, 11'h010, 16'hcdab);
    check("pio len", 16'(last_len > 10'd7 && last_len < 10'd13), 16'h1);
    refuse(CHS_LANE_WORD, 1'b0, 1'b1, 11'h010);
    ext_cycles <= 10'd400;
    card_op(CHS_LANE_WORD, 1'b0, 1'b0, 11'h010, 16'h0000);
    check("timeout", {15'h0000, st[CHS_ST_TIMEOUT]}, 16'h0001);
    ext_cycles <= 10'd0;
    $display("test extend done");
  endtask
  task automatic t_flags;
    logic [3:0] exp_t [0:2] = '{4'h0, 4'h3, 4'hd};
    for (int m = 0; m < 3; m++) begin
      set_mode(2'(m), 1'b0);
      sw_read(CHS_REG_STATUS, rv);
      check("pin flags", {12'h000, rv[7:4]}, {12'h000, exp_t[m]});
    end
    set_mode(CHS_MODE_ATA, 1'b1);
    chs_card_model_inst.send_burst(5);
    repeat (3) @(posedge sys_clk);
    sw_read(CHS_REG_BURST_CNT, rv);
    check("burst count", rv, 16'h0005);
    sw_read(CHS_REG_BURST_WORD, rv);
    check("burst word", rv, 16'h5a04);
    set_mode(CHS_MODE_MEM, 1'b0);
    $display("test flags done");
  endtask
  // ==========================================================
  // Run control
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    fails++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    mode = CHS_MODE_MEM;
    ext_cycles = 10'd0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_common();
    t_attr();
    t_extend();
    t_flags();
    print_verdict();
  end
endmodule

/* File: design/chs_burst_cap.sv */
// Capture unit: takes one data word on each edge of the read burst strobe
`timescale 1ns/1ps
module chs_burst_cap
  import chs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  chs_burst_if.cap bus
);

  typedef struct packed {
    logic        prev;
    logic [15:0] word;
    logic        valid;
    logic [7:0]  count;
  } chs_cap_s;

  chs_cap_s cap_reg;
  chs_cap_s cap_next;

  // ==========================================================
  // Both edges count; strobe is sampled, so it must stay below sys_clk/2
  always_comb begin
    cap_next       = cap_reg;
    cap_next.valid = 1'b0;
    cap_next.prev  = bus.strobe_lvl;
    if (!bus.enable) begin
      cap_next.count = 8'h00;
    end else if (bus.strobe_lvl != cap_reg.prev) begin
      cap_next.word  = bus.data_in;
      cap_next.valid = 1'b1;
      cap_next.count = 8'(cap_reg.count + 8'h01);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_reg <= '0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  assign bus.word  = cap_reg.word;
  assign bus.valid = cap_reg.valid;
  assign bus.count = cap_reg.count;

  a_both_edges_taken:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (bus.enable && (bus.strobe_lvl != cap_reg.prev))
        |=> (cap_reg.valid && cap_reg.word == $past(bus.data_in)))
    else $error("burst strobe edge did not capture a word");

endmodule

/* File: design/chs_host.sv */
// Host controller: drives card selects, strobes and address for memory cycles
//
// Overview of operation
// - Host captures burst data on both edges
// - Memory mode: write strobe for common and config writes
// - I/O mode: write strobe only for config
// - ATA mode: write strobe held high
// - Attribute writes only to config addresses
// - Config base reset to a fixed value, programmable by software
// - Attribute select high common, low attribute
`timescale 1ns/1ps
module chs_host
  import chs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output      logic [15:0] sw_rdata,
  output      logic [10:0] card_addr,
  output      logic        low_byte_select_n,
  output      logic        high_byte_select_n,
  output      logic        attr_select_n,
  output      logic        out_strobe_n,
  output      logic        wr_strobe_n,
  input  wire logic [15:0] card_data_in,
  output      logic [15:0] card_data_out,
  output      logic        card_data_oe,
  input  wire logic        cycle_hold_n,
  input  wire logic        pio_extend_n,
  input  wire logic        burst_accept_n,
  input  wire logic        read_burst_strobe,
  input  wire logic        write_protect,
  input  wire logic        port_word_capable_n,
  input  wire logic        word_cycle_expect_n
);
  import chs_pkg::*;

  typedef struct packed {
    chs_state_e  st;
    logic [8:0]  cnt;
    logic [8:0]  ext;
    chs_mode_e   mode;
    logic        burst_en;
    logic [10:0] cfg_base;
    logic        cmd_wr;
    logic        cmd_attr;
    logic [1:0]  cmd_lane;
    logic [10:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        done;
    logic        refused;
    logic        timeout;
    logic        lbs_n;
    logic        hbs_n;
    logic        attr_n;
    logic        oe_n;
    logic        we_n;
    logic [15:0] dout;
    logic        doe;
    logic [15:0] sw_rdata;
  } chs_host_s;

  chs_host_s host_reg;
  chs_host_s host_next;

  chs_burst_if burst ();

  chs_burst_cap u_cap (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .bus     (burst.cap)
  );

  assign burst.strobe_lvl = read_burst_strobe;
  assign burst.data_in    = card_data_in;
  assign burst.enable     = host_reg.burst_en &&
                            (host_reg.mode == CHS_MODE_ATA);

  // ==========================================================
  // Command screening
  logic        go_req;
  logic        n_wr;
  logic        n_attr;
  logic [1:0]  n_lane;
  logic        bad_cmd;
  logic        extended;
  logic [15:0] status_word;

  assign go_req = sw_wr && (sw_addr == CHS_REG_CTRL) &&
                  sw_wdata[CHS_CTRL_GO];
  assign n_wr   = sw_wdata[CHS_CTRL_WRITE];
  assign n_attr = sw_wdata[CHS_CTRL_ATTR];
  assign n_lane = sw_wdata[CHS_CTRL_LANE +: 2];

  // Refused commands never reach the pins, so the card sees no bad cycle
  always_comb begin
    bad_cmd = (n_lane == 2'h0);
    if (n_attr && (host_reg.addr[0] || n_lane == CHS_LANE_HIGH)) begin
      bad_cmd = 1'b1;
    end
    if (n_attr && n_wr &&
        host_reg.addr[10:3] != host_reg.cfg_base[10:3]) begin
      bad_cmd = 1'b1;
    end
    if (!n_attr && n_lane == CHS_LANE_WORD && host_reg.addr[0]) begin
      bad_cmd = 1'b1;
    end
    if (host_reg.mode == CHS_MODE_IO && n_wr && !n_attr) begin
      bad_cmd = 1'b1;
    end
    if (host_reg.mode == CHS_MODE_ATA && n_wr) begin
      bad_cmd = 1'b1;
    end
  end

  // Which extend input applies depends on the card's mode
  assign extended = (host_reg.mode == CHS_MODE_ATA) ?
                    !pio_extend_n : !cycle_hold_n;

  always_comb begin
    status_word                 = 16'h0000;
    status_word[CHS_ST_BUSY]    = (host_reg.st != CHS_IDLE);
    status_word[CHS_ST_DONE]    = host_reg.done;
    status_word[CHS_ST_REFUSED] = host_reg.refused;
    status_word[CHS_ST_TIMEOUT] = host_reg.timeout;
    status_word[CHS_ST_WPROT]   = write_protect;
    status_word[CHS_ST_PORT16]  = !port_word_capable_n;
    status_word[CHS_ST_WORDCYC] = !word_cycle_expect_n;
    status_word[CHS_ST_BACCEPT] = !burst_accept_n;
    status_word[CHS_ST_HOLD]    = !cycle_hold_n;
  end

  // ==========================================================
  // Next state
  always_comb begin
    host_next          = host_reg;
    host_next.sw_rdata = 16'h0000;

    if (sw_rd) begin
      case (sw_addr)
        CHS_REG_ADDR:       host_next.sw_rdata = {5'h00, host_reg.addr};
        CHS_REG_WDATA:      host_next.sw_rdata = host_reg.wdata;
        CHS_REG_RDATA:      host_next.sw_rdata = host_reg.rdata;
        CHS_REG_STATUS:     host_next.sw_rdata = status_word;
        CHS_REG_MODE:       host_next.sw_rdata =
                              {13'h0000, host_reg.burst_en, host_reg.mode};
        CHS_REG_CFG_BASE:   host_next.sw_rdata = {5'h00, host_reg.cfg_base};
        CHS_REG_BURST_WORD: host_next.sw_rdata = burst.word;
        CHS_REG_BURST_CNT:  host_next.sw_rdata = {8'h00, burst.count};
        default:            host_next.sw_rdata = 16'h0000;
      endcase
    end

    if (sw_wr) begin
      case (sw_addr)
        CHS_REG_ADDR:     host_next.addr = sw_wdata[10:0];
        CHS_REG_WDATA:    host_next.wdata = sw_wdata;
        CHS_REG_MODE: begin
          host_next.mode     = chs_mode_e'(sw_wdata[CHS_MODE_SEL +: 2]);
          host_next.burst_en = sw_wdata[CHS_MODE_BURST];
        end
        CHS_REG_CFG_BASE: host_next.cfg_base = sw_wdata[10:0];
        CHS_REG_STATUS: begin
          // Write one to clear; a same-cycle hardware set wins below
          if (sw_wdata[CHS_ST_DONE])    host_next.done    = 1'b0;
          if (sw_wdata[CHS_ST_REFUSED]) host_next.refused = 1'b0;
          if (sw_wdata[CHS_ST_TIMEOUT]) host_next.timeout = 1'b0;
        end
        default: ;
      endcase
    end

    case (host_reg.st)
      CHS_IDLE: begin
        if (go_req && bad_cmd) begin
          host_next.refused = 1'b1;
        end else if (go_req) begin
          host_next.st       = CHS_SETUP;
          host_next.cnt      = CHS_SETUP_CYC - 9'h001;
          host_next.ext      = 9'h000;
          host_next.cmd_wr   = n_wr;
          host_next.cmd_attr = n_attr;
          host_next.cmd_lane = n_attr ? CHS_LANE_LOW : n_lane;
          host_next.attr_n   = !n_attr;
          host_next.lbs_n    = !(n_attr || n_lane[0]);
          host_next.hbs_n    = n_attr || !n_lane[1];
          host_next.dout     = host_reg.wdata;
          host_next.doe      = n_wr;
        end
      end
      CHS_SETUP: begin
        if (host_reg.cnt == 9'h000) begin
          host_next.st   = CHS_ACTIVE;
          host_next.cnt  = CHS_STROBE_CYC - 9'h001;
          host_next.oe_n = host_reg.cmd_wr;
          host_next.we_n = !host_reg.cmd_wr;
        end else begin
          host_next.cnt = host_reg.cnt - 9'h001;
        end
      end
      CHS_ACTIVE: begin
        if (host_reg.cnt != 9'h000) begin
          host_next.cnt = host_reg.cnt - 9'h001;
        end else if (extended && host_reg.ext < CHS_EXTEND_MAX) begin
          host_next.ext = host_reg.ext + 9'h001;
        end else begin
          // Giving up on a stuck card beats hanging software forever
          host_next.timeout = host_next.timeout | extended;
          if (!host_reg.cmd_wr) begin
            host_next.rdata = card_data_in &
              {{8{host_reg.cmd_lane[1]}}, {8{host_reg.cmd_lane[0]}}};
          end
          host_next.oe_n = 1'b1;
          host_next.we_n = 1'b1;
          host_next.st   = CHS_RECOVER;
          host_next.cnt  = CHS_RECOVER_CYC - 9'h001;
        end
      end
      CHS_RECOVER: begin
        // Selects drop too, so the card sees standby between cycles
        host_next.lbs_n  = 1'b1;
        host_next.hbs_n  = 1'b1;
        host_next.attr_n = 1'b1;
        host_next.doe    = 1'b0;
        if (host_reg.cnt == 9'h000) begin
          host_next.st   = CHS_IDLE;
          host_next.done = 1'b1;
        end else begin
          host_next.cnt = host_reg.cnt - 9'h001;
        end
      end
      default: host_next.st = CHS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_reg          <= '0;
      host_reg.st       <= CHS_IDLE;
      host_reg.mode     <= CHS_MODE_MEM;
      host_reg.cfg_base <= CHS_CFG_BASE_RST;
      host_reg.lbs_n    <= 1'b1;
      host_reg.hbs_n    <= 1'b1;
      host_reg.attr_n   <= 1'b1;
      host_reg.oe_n     <= 1'b1;
      host_reg.we_n     <= 1'b1;
    end else begin
      host_reg <= host_next;
    end
  end

  assign sw_rdata           = host_reg.sw_rdata;
  assign card_addr          = host_reg.addr;
  assign low_byte_select_n  = host_reg.lbs_n;
  assign high_byte_select_n = host_reg.hbs_n;
  assign attr_select_n      = host_reg.attr_n;
  assign out_strobe_n       = host_reg.oe_n;
  assign wr_strobe_n        = host_reg.we_n;
  assign card_data_out      = host_reg.dout;
  assign card_data_oe       = host_reg.doe;

  // ==========================================================
  // Checks
  a_ata_no_write:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (host_reg.mode == CHS_MODE_ATA && host_reg.st == CHS_IDLE)
        |=> wr_strobe_n [*3])
    else $error("write strobe pulsed in ATA mode");

  a_io_write_cfg:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (host_reg.mode == CHS_MODE_IO && !wr_strobe_n) |-> !attr_select_n)
    else $error("I/O mode write outside attribute space");

  a_attr_low_lane:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (!attr_select_n && (!out_strobe_n || !wr_strobe_n))
        |-> (high_byte_select_n && !low_byte_select_n))
    else $error("attribute access not on low lane");

  a_attr_even_addr:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (!attr_select_n && !low_byte_select_n) |-> !card_addr[0])
    else $error("attribute access at odd address");

  a_attr_write_cfg:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (!attr_select_n && !wr_strobe_n)
        |-> (card_addr[10:3] == host_reg.cfg_base[10:3]))
    else $error("attribute write outside config window");

  a_idle_standby:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (host_reg.st == CHS_RECOVER) |=>
        (low_byte_select_n && high_byte_select_n && !card_data_oe))
    else $error("selects or data held after a cycle");

  a_hold_extends:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (host_reg.st == CHS_ACTIVE && host_reg.cnt == 9'h000 &&
       host_reg.mode != CHS_MODE_ATA && !cycle_hold_n &&
       host_reg.ext < CHS_EXTEND_MAX)
        |=> (host_reg.st == CHS_ACTIVE && (!out_strobe_n || !wr_strobe_n)))
    else $error("cycle ended while card held it");

  a_pio_extends:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (host_reg.st == CHS_ACTIVE && host_reg.cnt == 9'h000 &&
       host_reg.mode == CHS_MODE_ATA && !pio_extend_n &&
       host_reg.ext < CHS_EXTEND_MAX) |=> host_reg.st == CHS_ACTIVE)
    else $error("ATA cycle ended while card extended it");

  a_strobe_width:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      $fell(out_strobe_n && wr_strobe_n)
        |-> (!(out_strobe_n && wr_strobe_n)) [*4])
    else $error("strobe shorter than four cycles");

  a_wait_bounded:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(host_reg.st == CHS_ACTIVE)
        |-> ##[1:310] host_reg.st == CHS_RECOVER)
    else $error("active phase never ended");

  a_attr_select_kind:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      (go_req && !bad_cmd && host_reg.st == CHS_IDLE)
        |=> (attr_select_n == !$past(n_attr))
        ##1 (attr_select_n == !$past(n_attr, 2))
        ##1 (attr_select_n == !$past(n_attr, 3)))
    else $error("attribute select does not match command");

endmodule

/* File: inc/chs_burst_if.sv */
// Interface: read burst capture between the controller and its capture unit
`timescale 1ns/1ps
interface chs_burst_if;
  logic        strobe_lvl;
  logic        enable;
  logic [15:0] data_in;
  logic [15:0] word;
  logic        valid;
  logic [7:0]  count;

  modport cap (input strobe_lvl, enable, data_in,
               output word, valid, count);
  modport ctl (output strobe_lvl, enable, data_in,
               input word, valid, count);
endinterface

/* File: inc/chs_pkg.sv */
// Package: constants, register map and types of the card host space controller
package chs_pkg;

  // ==========================================================
  // Timing
  localparam int CHS_CLK_NS        = 40;
  localparam int CHS_SETUP_NS      = 80;
  localparam int CHS_STROBE_NS     = 160;
  localparam int CHS_RECOVER_NS    = 40;
  localparam int CHS_EXTEND_MAX_NS = 12000;
  // Least times round up, the longest wait rounds down
  localparam logic [8:0] CHS_SETUP_CYC   =
    9'((CHS_SETUP_NS + CHS_CLK_NS - 1) / CHS_CLK_NS);
  localparam logic [8:0] CHS_STROBE_CYC  =
    9'((CHS_STROBE_NS + CHS_CLK_NS - 1) / CHS_CLK_NS);
  localparam logic [8:0] CHS_RECOVER_CYC =
    9'((CHS_RECOVER_NS + CHS_CLK_NS - 1) / CHS_CLK_NS);
  localparam logic [8:0] CHS_EXTEND_MAX  =
    9'(CHS_EXTEND_MAX_NS / CHS_CLK_NS);

  // ==========================================================
  // Software register indexes
  localparam logic [3:0] CHS_REG_CTRL       = 4'h0;
  localparam logic [3:0] CHS_REG_ADDR       = 4'h1;
  localparam logic [3:0] CHS_REG_WDATA      = 4'h2;
  localparam logic [3:0] CHS_REG_RDATA      = 4'h3;
  localparam logic [3:0] CHS_REG_STATUS     = 4'h4;
  localparam logic [3:0] CHS_REG_MODE       = 4'h5;
  localparam logic [3:0] CHS_REG_CFG_BASE   = 4'h6;
  localparam logic [3:0] CHS_REG_BURST_WORD = 4'h7;
  localparam logic [3:0] CHS_REG_BURST_CNT  = 4'h8;

  // CTRL fields
  localparam int CHS_CTRL_GO    = 0;
  localparam int CHS_CTRL_WRITE = 1;
  localparam int CHS_CTRL_ATTR  = 2;
  localparam int CHS_CTRL_LANE  = 3;
  // MODE fields
  localparam int CHS_MODE_SEL   = 0;
  localparam int CHS_MODE_BURST = 2;
  // STATUS fields
  localparam int CHS_ST_BUSY    = 0;
  localparam int CHS_ST_DONE    = 1;
  localparam int CHS_ST_REFUSED = 2;
  localparam int CHS_ST_TIMEOUT = 3;
  localparam int CHS_ST_WPROT   = 4;
  localparam int CHS_ST_PORT16  = 5;
  localparam int CHS_ST_WORDCYC = 6;
  localparam int CHS_ST_BACCEPT = 7;
  localparam int CHS_ST_HOLD    = 8;

  // Byte lane codes
  localparam logic [1:0] CHS_LANE_LOW  = 2'h1;
  localparam logic [1:0] CHS_LANE_HIGH = 2'h2;
  localparam logic [1:0] CHS_LANE_WORD = 2'h3;

  // Configuration register window in attribute space
  localparam logic [10:0] CHS_CFG_BASE_RST   = 11'h200;
  localparam logic [10:0] CHS_CFG_OPTION_OFS = 11'h000;
  localparam logic [10:0] CHS_CFG_STATUS_OFS = 11'h002;
  localparam logic [10:0] CHS_CFG_PINREP_OFS = 11'h004;
  localparam logic [10:0] CHS_CFG_SOCKET_OFS = 11'h006;

  typedef enum logic [1:0] {
    CHS_MODE_MEM = 2'h0,
    CHS_MODE_IO  = 2'h1,
    CHS_MODE_ATA = 2'h2
  } chs_mode_e;

  // Gray along idle, setup, active, recover
  typedef enum logic [1:0] {
    CHS_IDLE    = 2'h0,
    CHS_SETUP   = 2'h1,
    CHS_ACTIVE  = 2'h3,
    CHS_RECOVER = 2'h2
  } chs_state_e;

endpackage
